// >>> hw/bop_pkg.sv
`default_nettype none
package bop_pkg;
    // ----------------------------------------------------------------
    // register map: word index, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [2:0] IDX_UPDATE = 3'h0;
    localparam logic [2:0] IDX_SELECT = 3'h1;
    localparam logic [2:0] IDX_SCAN = 3'h2;
    localparam logic [2:0] IDX_MASK = 3'h3;
    localparam logic [2:0] IDX_COMMIT = 3'h4;
    localparam logic [2:0] IDX_STATUS = 3'h5;

    // ----------------------------------------------------------------
    // update state field
    // ----------------------------------------------------------------
    localparam logic [1:0] UPD_COMPLETE = 2'h0;
    localparam logic [1:0] UPD_UNDERWAY = 2'h1;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [1:0] SCAN_RESET = 2'h0;
    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam int SCAN_FOUND_BIT = 0;
    localparam int SCAN_REQ_BIT = 1;
    localparam int MASK_WAKE_BIT = 0;
    localparam int MASK_BUTTON_BIT = 1;
    localparam int MASK_WDOG_BIT = 2;
    localparam int MASK_TIMEOUT_BIT = 3;
    localparam int MASK_EVF_BIT = 4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_S = 60;
    localparam int TIMEOUT_TICKS = TIMEOUT_S * 1000;
endpackage : bop_pkg
`default_nettype wire

// >>> hw/bop_timeout.sv
`timescale 1ns/1ps
`default_nettype none
module bop_timeout #(
    parameter int TICK_CYC = bop_pkg::TICK_CYC,
    parameter int TIMEOUT_TICKS = bop_pkg::TIMEOUT_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic restart_i,
    output logic expire_o
);
    logic [31:0] div_r;
    logic [31:0] div_nxt;
    logic [31:0] left_r;
    logic [31:0] left_nxt;
    logic expire_nxt;
    logic tick;

    // ----------------------------------------------------------------
    // one-cycle tick enable, then countdown in ticks
    // ----------------------------------------------------------------
    always_comb begin
        tick = (div_r == 32'(TICK_CYC - 1));
        div_nxt = tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
        left_nxt = left_r;
        expire_nxt = 1'b0;
        if (restart_i || !run_i) begin
            // full reload on every chassis command
            left_nxt = 32'(TIMEOUT_TICKS);
            div_nxt = 32'h0000_0000;
        end else if (tick && left_r != 32'h0000_0000) begin
            left_nxt = left_r - 32'h0000_0001;
            expire_nxt = (left_r == 32'h0000_0001);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= 32'h0000_0000;
            left_r <= 32'(TIMEOUT_TICKS);
            expire_o <= 1'b0;
        end else begin
            div_r <= div_nxt;
            left_r <= left_nxt;
            expire_o <= expire_nxt;
        end
    end
endmodule : bop_timeout
`default_nettype wire

// >>> hw/bop_bank.sv
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module bop_bank #(
    parameter int TICK_CYC = bop_pkg::TICK_CYC,
    parameter int TIMEOUT_TICKS = bop_pkg::TIMEOUT_TICKS,
    parameter bit ROLLBACK_EN = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sys_reset_i,
    input wire logic power_down_i,
    input wire logic evf_reset_i,
    input wire logic wdog_reset_i,
    input wire logic button_reset_i,
    input wire logic wake_powerup_i,
    input wire logic chassis_cmd_i,
    input wire logic valid_set_i,
    input wire logic valid_clr_i,
    output logic boot_valid_o,
    output logic [1:0] update_state_o,
    output logic [7:0] partition_select_o,
    output logic scan_request_o
);
    logic [1:0] upd_r, upd_nxt;
    logic [7:0] sel_r, sel_nxt;
    logic [1:0] scan_r, scan_nxt;
    logic [4:0] mask_r, mask_nxt;
    logic [7:0] sel_snap_r, sel_snap_nxt;
    logic [1:0] scan_snap_r, scan_snap_nxt;
    logic [4:0] mask_snap_r, mask_snap_nxt;
    logic commit_r, commit_nxt;
    logic valid_r, valid_nxt;
    logic ack_nxt;
    logic [31:0] dat_nxt;
    logic [2:0] idx;
    logic mapped;
    logic expire;
    logic auto_clr;
    logic to_complete;
    logic [1:0] upd_wr;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    function automatic logic wr_hit(input logic [2:0] i, input logic [2:0] r,
                                    input logic ok, input logic ack, input logic we,
                                    input logic lane);
        wr_hit = ok && ack && we && lane && (i == r);
    endfunction : wr_hit

    assign idx = wb_adr_i[4:2];
    assign mapped = (wb_adr_i[7:5] == 3'h0) && (idx <= bop_pkg::IDX_STATUS);

    // ----------------------------------------------------------------
    // 60 s chassis command watchdog
    // ----------------------------------------------------------------
    bop_timeout #(
        .TICK_CYC(TICK_CYC),
        .TIMEOUT_TICKS(TIMEOUT_TICKS)
    ) u_timeout (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(valid_r),
        .restart_i(chassis_cmd_i),
        .expire_o(expire)
    );

    // ----------------------------------------------------------------
    // wishbone slave: ack one cycle after request, write at ack edge
    // ----------------------------------------------------------------
    always_comb begin
        ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
        dat_nxt = 32'h0000_0000;
        if (ack_nxt && mapped) begin
            case (idx)
                bop_pkg::IDX_UPDATE: dat_nxt = {30'h0000_0000, upd_r};
                bop_pkg::IDX_SELECT: dat_nxt = {24'h00_0000, sel_r};
                bop_pkg::IDX_SCAN: dat_nxt = {30'h0000_0000, scan_r};
                bop_pkg::IDX_MASK: dat_nxt = {27'h000_0000, mask_r};
                bop_pkg::IDX_STATUS: dat_nxt = {30'h0000_0000, commit_r, valid_r};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= ack_nxt;
            wb_dat_o <= dat_nxt;
        end
    end

    // ----------------------------------------------------------------
    // parameter storage
    // ----------------------------------------------------------------
    always_comb begin
        upd_nxt = upd_r;
        sel_nxt = sel_r;
        scan_nxt = scan_r;
        mask_nxt = mask_r;
        sel_snap_nxt = sel_snap_r;
        scan_snap_nxt = scan_snap_r;
        mask_snap_nxt = mask_snap_r;
        commit_nxt = commit_r;
        upd_wr = wb_dat_i[1:0];
        // writes land immediately, whatever the update state says
        if (wr_hit(idx, bop_pkg::IDX_SELECT, mapped, wb_ack_o, wb_we_i, wb_sel_i[0])) begin
            sel_nxt = wb_dat_i[7:0];
        end
        if (wr_hit(idx, bop_pkg::IDX_SCAN, mapped, wb_ack_o, wb_we_i, wb_sel_i[0])) begin
            scan_nxt = wb_dat_i[1:0];
        end
        if (wr_hit(idx, bop_pkg::IDX_MASK, mapped, wb_ack_o, wb_we_i, wb_sel_i[0])) begin
            mask_nxt = wb_dat_i[4:0];
        end
        if (wr_hit(idx, bop_pkg::IDX_COMMIT, mapped, wb_ack_o, wb_we_i, wb_sel_i[0])) begin
            commit_nxt = 1'b1;
        end
        // reserved codes are refused, the field keeps its value
        if (wr_hit(idx, bop_pkg::IDX_UPDATE, mapped, wb_ack_o, wb_we_i, wb_sel_i[0])
            && (upd_wr == bop_pkg::UPD_COMPLETE || upd_wr == bop_pkg::UPD_UNDERWAY)) begin
            upd_nxt = upd_wr;
        end
        // volatile field drops back on system reset or power-down
        if ((sys_reset_i || power_down_i) && upd_r == bop_pkg::UPD_UNDERWAY) begin
            upd_nxt = bop_pkg::UPD_COMPLETE;
        end
        to_complete = (upd_r == bop_pkg::UPD_UNDERWAY) && (upd_nxt == bop_pkg::UPD_COMPLETE);
        if (upd_r == bop_pkg::UPD_COMPLETE && upd_nxt == bop_pkg::UPD_UNDERWAY) begin
            // snapshot taken at entry, so later writes stay visible at once
            sel_snap_nxt = sel_nxt;
            scan_snap_nxt = scan_nxt;
            mask_snap_nxt = mask_nxt;
            commit_nxt = 1'b0;
        end
        if (ROLLBACK_EN && to_complete && !commit_nxt) begin
            sel_nxt = sel_snap_r;
            scan_nxt = scan_snap_r;
            mask_nxt = mask_snap_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upd_r <= bop_pkg::UPD_COMPLETE;
            sel_r <= bop_pkg::SELECT_RESET;
            scan_r <= bop_pkg::SCAN_RESET;
            mask_r <= bop_pkg::MASK_RESET;
            sel_snap_r <= bop_pkg::SELECT_RESET;
            scan_snap_r <= bop_pkg::SCAN_RESET;
            mask_snap_r <= bop_pkg::MASK_RESET;
            commit_r <= 1'b0;
        end else begin
            upd_r <= upd_nxt;
            sel_r <= sel_nxt;
            scan_r <= scan_nxt;
            mask_r <= mask_nxt;
            sel_snap_r <= sel_snap_nxt;
            scan_snap_r <= scan_snap_nxt;
            mask_snap_r <= mask_snap_nxt;
            commit_r <= commit_nxt;
        end
    end

    // ----------------------------------------------------------------
    // boot flag valid bit and its automatic clearing
    // ----------------------------------------------------------------
    always_comb begin
        auto_clr = (evf_reset_i && !mask_r[bop_pkg::MASK_EVF_BIT])
            || (expire && !mask_r[bop_pkg::MASK_TIMEOUT_BIT])
            || (wdog_reset_i && !mask_r[bop_pkg::MASK_WDOG_BIT])
            || (button_reset_i && !mask_r[bop_pkg::MASK_BUTTON_BIT])
            || (wake_powerup_i && !mask_r[bop_pkg::MASK_WAKE_BIT]);
        valid_nxt = valid_r;
        if (auto_clr || valid_clr_i) begin
            valid_nxt = 1'b0;
        end
        // a set in the same cycle as any clear wins
        if (valid_set_i) begin
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_r <= 1'b0;
            boot_valid_o <= 1'b0;
            update_state_o <= bop_pkg::UPD_COMPLETE;
            partition_select_o <= bop_pkg::SELECT_RESET;
            scan_request_o <= 1'b0;
        end else begin
            valid_r <= valid_nxt;
            boot_valid_o <= valid_nxt;
            update_state_o <= upd_nxt;
            partition_select_o <= sel_nxt;
            scan_request_o <= scan_nxt[bop_pkg::SCAN_REQ_BIT];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_upd_legal: assert property (
        upd_r == bop_pkg::UPD_COMPLETE || upd_r == bop_pkg::UPD_UNDERWAY)
        else $error("update state holds a reserved code");

    chk_upd_drop: assert property (
        (sys_reset_i || power_down_i) && upd_r == bop_pkg::UPD_UNDERWAY
        |=> upd_r == bop_pkg::UPD_COMPLETE && update_state_o == bop_pkg::UPD_COMPLETE)
        else $error("update state not returned to complete");

    chk_sel_write: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[0] && mapped && idx == bop_pkg::IDX_SELECT
        && !(ROLLBACK_EN && (sys_reset_i || power_down_i))
        |=> sel_r == $past(wb_dat_i[7:0]))
        else $error("selector write was not taken");

    chk_rd_select: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && mapped && idx == bop_pkg::IDX_SELECT
        |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(sel_r)})
        else $error("selector read data wrong");

    chk_evf_keep: assert property (
        evf_reset_i && mask_r[bop_pkg::MASK_EVF_BIT] && valid_r
        && !valid_clr_i && !wdog_reset_i && !button_reset_i && !wake_powerup_i && !expire
        |=> valid_r)
        else $error("valid bit lost despite event filter mask");

    chk_tmo_clear: assert property (
        expire && !mask_r[bop_pkg::MASK_TIMEOUT_BIT] && !valid_set_i |=> !valid_r)
        else $error("valid bit kept after timeout");

    chk_tmo_restart: assert property (
        chassis_cmd_i |=> !expire [*2])
        else $error("timeout fired right after chassis command");

    chk_btn_clear: assert property (
        button_reset_i && !mask_r[bop_pkg::MASK_BUTTON_BIT] && !valid_set_i
        |=> !valid_r && !boot_valid_o)
        else $error("push-button reset did not clear valid bit");

    chk_wake_clear: assert property (
        wake_powerup_i && !mask_r[bop_pkg::MASK_WAKE_BIT] && !valid_set_i |=> !boot_valid_o)
        else $error("wake power-up did not clear valid bit");

    chk_mask_keep: assert property (
        !(wb_ack_o && wb_we_i) && !(ROLLBACK_EN && (sys_reset_i || power_down_i))
        |=> mask_r == $past(mask_r))
        else $error("mask changed without a write");

    chk_wdog_keep: assert property (
        wdog_reset_i && mask_r[bop_pkg::MASK_WDOG_BIT] && valid_r
        && !valid_clr_i && !evf_reset_i && !button_reset_i && !wake_powerup_i && !expire
        |=> valid_r && boot_valid_o)
        else $error("valid bit lost despite watchdog mask");

    chk_upd_refuse: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[0] && mapped && idx == bop_pkg::IDX_UPDATE && wb_dat_i[1]
        && !sys_reset_i && !power_down_i
        |=> upd_r == $past(upd_r))
        else $error("reserved update code was stored");

    chk_scan_write: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[0] && mapped && idx == bop_pkg::IDX_SCAN
        && !(ROLLBACK_EN && (sys_reset_i || power_down_i))
        |=> scan_r == $past(wb_dat_i[1:0]) && scan_request_o == $past(wb_dat_i[bop_pkg::SCAN_REQ_BIT]))
        else $error("scan write was not taken");

    chk_rollback: assert property (
        ROLLBACK_EN && wb_ack_o && wb_we_i && wb_sel_i[0] && mapped && idx == bop_pkg::IDX_UPDATE
        && wb_dat_i[1:0] == bop_pkg::UPD_COMPLETE && upd_r == bop_pkg::UPD_UNDERWAY && !commit_r
        |=> sel_r == $past(sel_snap_r) && partition_select_o == $past(sel_snap_r))
        else $error("pending selector data not discarded");

    cov_write_sel: cover property (wb_ack_o && wb_we_i && idx == bop_pkg::IDX_SELECT);
    cov_underway_reset: cover property (upd_r == bop_pkg::UPD_UNDERWAY ##1 sys_reset_i);
    cov_timeout: cover property (expire && valid_r);
    cov_masked_wdog: cover property (wdog_reset_i && mask_r[bop_pkg::MASK_WDOG_BIT] && valid_r);
endmodule : bop_bank
`default_nettype wire

// >>> sim/bop_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module bop_sys_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [2:0] kind_i,
    output logic sys_reset_o,
    output logic power_down_o,
    output logic evf_reset_o,
    output logic wdog_reset_o,
    output logic button_reset_o,
    output logic wake_powerup_o,
    output logic chassis_cmd_o
);
    // ------------------------------------------------------------
    // one-cycle event pulses, kind: 0 wake, 1 button, 2 watchdog,
    // 3 chassis command, 4 event filter, 5 plain reset, 6 power down
    // ------------------------------------------------------------
    logic [7:0] pulse_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || !go_i) begin
            pulse_r <= 8'h00;
        end else begin
            pulse_r <= 8'h01 << kind_i;
        end
    end
    // every reset cause arrives together with the system reset itself
    assign sys_reset_o = pulse_r[5] | pulse_r[0] | pulse_r[1] | pulse_r[2] | pulse_r[4];
    assign power_down_o = pulse_r[6];
    assign wake_powerup_o = pulse_r[0];
    assign button_reset_o = pulse_r[1];
    assign wdog_reset_o = pulse_r[2];
    assign chassis_cmd_o = pulse_r[3];
    assign evf_reset_o = pulse_r[4];
endmodule : bop_sys_model
`default_nettype wire

// >>> sim/test_boot_option_parameter_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_boot_option_parameter_bank;
    logic clk_i, rst_i, cyc, stb, we, go, vset_r, vclr, ack, valid;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd;
    logic [2:0] kind;
    logic [1:0] upd;
    logic [7:0] psel;
    logic sysr, pdn, evf, wdg, btn, wake, chas, scanr;
    int num_errors = 0;
    int comparisons = 0;

    bop_bank #(.TICK_CYC(4), .TIMEOUT_TICKS(5), .ROLLBACK_EN(1'b1)) u_bop_bank (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sys_reset_i(sysr), .power_down_i(pdn), .evf_reset_i(evf), .wdog_reset_i(wdg),
        .button_reset_i(btn), .wake_powerup_i(wake), .chassis_cmd_i(chas),
        .valid_set_i(vset_r), .valid_clr_i(vclr), .boot_valid_o(valid),
        .update_state_o(upd), .partition_select_o(psel), .scan_request_o(scanr));
    bop_sys_model u_bop_sys_model (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .kind_i(kind), .sys_reset_o(sysr),
        .power_down_o(pdn), .evf_reset_o(evf), .wdog_reset_o(wdg), .button_reset_o(btn),
        .wake_powerup_o(wake), .chassis_cmd_o(chas));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // bus and event tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // holds the request until ack is sampled high, data taken at that edge
    task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {3'h0, idx, 2'h0};
        wdat <= d;
        sel <= 4'hF;
        // no cycle budget of its own: only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rchk(input logic [2:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rchk

    task automatic ev(input logic [2:0] k);
        @(posedge clk_i);
        go <= 1'b1;
        kind <= k;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : ev

    task automatic set_valid;
        @(posedge clk_i);
        vset_r <= 1'b1;
        @(posedge clk_i);
        vset_r <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : set_valid

    task automatic end_sim;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        #(40 * 8000);
        num_errors++;
        end_sim();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        int b;
        logic m;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        go = 1'b0;
        kind = 3'h0;
        vset_r = 1'b0;
        vclr = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(3'h0, 32'h0000_0000);
        rchk(3'h1, 32'h0000_0000);
        rchk(3'h2, 32'h0000_0000);
        rchk(3'h3, 32'h0000_0000);
        wb(1'b1, 3'h3, 32'h0000_00FF);
        rchk(3'h3, 32'h0000_001F);
        // bios side: request a scan, then report the partition found
        wb(1'b1, 3'h2, 32'h0000_0002);
        rchk(3'h2, 32'h0000_0002);
        chk({31'h0, scanr}, 32'h1);
        wb(1'b1, 3'h2, 32'h0000_0001);
        rchk(3'h2, 32'h0000_0001);
        chk({31'h0, scanr}, 32'h0);
        wb(1'b1, 3'h1, 32'h0000_00A5);
        @(negedge clk_i);
        chk({24'h0, psel}, 32'h0000_00A5);
        wb(1'b1, 3'h0, 32'h0000_0001);
        wb(1'b1, 3'h0, 32'h0000_0002);
        rchk(3'h0, 32'h0000_0001);
        wb(1'b1, 3'h1, 32'h0000_005A);
        rchk(3'h1, 32'h0000_005A);
        wb(1'b1, 3'h4, 32'h0000_0001);
        ev(3'h5);
        chk({30'h0, upd}, 32'h0);
        rchk(3'h1, 32'h0000_005A);
        // bios drops the found flag after a reset with no scan pending
        wb(1'b1, 3'h2, 32'h0000_0000);
        rchk(3'h2, 32'h0000_0000);
        wb(1'b1, 3'h0, 32'h0000_0001);
        ev(3'h6);
        rchk(3'h0, 32'h0000_0000);
        // pending data dropped when returning to complete without commit
        wb(1'b1, 3'h0, 32'h0000_0001);
        wb(1'b1, 3'h1, 32'h0000_003C);
        @(negedge clk_i);
        chk({24'h0, psel}, 32'h0000_003C);
        wb(1'b1, 3'h0, 32'h0000_0000);
        rchk(3'h1, 32'h0000_005A);
        wb(1'b1, 3'h0, 32'h0000_0001);
        wb(1'b1, 3'h1, 32'h0000_0077);
        wb(1'b1, 3'h4, 32'h0000_0001);
        wb(1'b1, 3'h0, 32'h0000_0000);
        rchk(3'h1, 32'h0000_0077);
        rchk(3'h7, 32'h0000_0000);
        // each cause but the timeout with only its own mask bit, then with every other bit
        for (b = 0; b < 5; b++) begin
            if (b != 3) begin
                for (int j = 0; j < 2; j++) begin
                    m = (j == 0);
                    wb(1'b1, 3'h3, m ? (32'h1 << b) : (32'h1F ^ (32'h1 << b)));
                    set_valid();
                    ev(b[2:0]);
                    chk({31'h0, valid}, {31'h0, m});
                end
            end
        end
        wb(1'b1, 3'h3, 32'h0000_0000);
        set_valid();
        repeat (15) @(posedge clk_i);
        ev(3'h3);
        repeat (12) @(posedge clk_i);
        chk({31'h0, valid}, 32'h1);
        repeat (10) @(posedge clk_i);
        chk({31'h0, valid}, 32'h0);
        wb(1'b1, 3'h3, 32'h0000_0008);
        set_valid();
        repeat (40) @(posedge clk_i);
        chk({31'h0, valid}, 32'h1);
        rchk(3'h5, 32'h0000_0003);
        // set and clear in one cycle: set wins, clear alone drops the bit
        @(posedge clk_i);
        vset_r <= 1'b1;
        vclr <= 1'b1;
        @(posedge clk_i);
        vset_r <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, valid}, 32'h1);
        @(posedge clk_i);
        vclr <= 1'b0;
        @(negedge clk_i);
        chk({31'h0, valid}, 32'h0);
        rchk(3'h5, 32'h0000_0002);
        end_sim();
    end
endmodule : test_boot_option_parameter_bank
`default_nettype wire
